// >>> rtl/pdm_ctrl.v
// serial mode control and per-channel driver state decode
`timescale 1ns/1ps
`include "pdm_defs.vh"
module pdm_ctrl #(
    parameter CHANNELS = `PDM_CHANNELS
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire ser_clk_i,
    input wire ser_data_i,
    input wire chip_sel_n_i,
    input wire dev_reset_n_i,
    input wire [CHANNELS-1:0] drive_data_i,
    input wire [CHANNELS-1:0] receive_ctrl_in_i,
    output reg [CHANNELS-1:0] low_leak_select_o,
    output reg [CHANNELS-1:0] slew_code_upper_o,
    output reg [CHANNELS-1:0] slew_code_lower_o,
    output reg [CHANNELS-1:0] termination_select_o,
    output reg [7*CHANNELS-1:0] slew_pct_o,
    output reg [5*CHANNELS-1:0] drv_state_o,
    output reg [CHANNELS-1:0] driver_en_o,
    output reg [CHANNELS-1:0] comp_en_o,
    output reg [CHANNELS-1:0] clamp_en_o,
    output reg [3:0] bit_count_o
);
    ////////////////////////////////////////////////////////////////
    // synchronised pins
    wire sclk_rise; // serial clock rising edge
    wire cs_n_lvl; // chip select level, active low
    wire cs_rise; // deselect edge: commit point
    wire cs_fall; // select edge: frame start
    wire sdata; // serial data level
    wire rst_n_lvl; // device reset level, active low
    reg [CHANNELS-1:0] drv_s1; // drive input first stage
    reg [CHANNELS-1:0] drv_s2; // drive input clean
    reg [CHANNELS-1:0] rcv_s1; // receive input first stage
    reg [CHANNELS-1:0] rcv_s2; // receive input clean
    reg [`PDM_WORD_BITS-1:0] serial_control_word; // shift register
    reg [`PDM_WORD_BITS-1:0] sdata_hold; // data aligned to clock edge
    reg [`PDM_MODE_BITS-1:0] mode [0:CHANNELS-1]; // per-channel latches
    // serial clock edge finder
    pdm_sync u_sclk (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(ser_clk_i),
        .level_o(),
        .rise_o(sclk_rise),
        .fall_o()
    );
    // chip select edge finder
    pdm_sync u_cs (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(~chip_sel_n_i),
        .level_o(),
        .rise_o(cs_fall),
        .fall_o(cs_rise)
    );
    // data path, same latency as the clock edge finder
    pdm_sync u_sdata (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(ser_data_i),
        .level_o(sdata),
        .rise_o(),
        .fall_o()
    );
    // device reset, inverted so the synced level reads high when asserted
    wire rst_lvl; // device reset asserted
    pdm_sync u_rst (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(~dev_reset_n_i),
        .level_o(rst_lvl),
        .rise_o(),
        .fall_o()
    );
    reg cs_active; // frame in progress, from synced edges
    assign cs_n_lvl = ~cs_active;
    assign rst_n_lvl = ~rst_lvl;
    ////////////////////////////////////////////////////////////////
    // high-speed inputs through two flops
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            drv_s1 <= {CHANNELS{1'b0}};
            drv_s2 <= {CHANNELS{1'b0}};
            rcv_s1 <= {CHANNELS{1'b0}};
            rcv_s2 <= {CHANNELS{1'b0}};
        end else begin
            drv_s1 <= drive_data_i;
            drv_s2 <= drv_s1;
            rcv_s1 <= receive_ctrl_in_i;
            rcv_s2 <= rcv_s1;
        end
    end
    ////////////////////////////////////////////////////////////////
    // shift register and bit counter
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            serial_control_word <= 8'h00;
            bit_count_o <= 4'h0;
            cs_active <= 1'b0;
        end else begin
            if (cs_fall) begin
                // new frame restarts the count
                cs_active <= 1'b1;
                bit_count_o <= 4'h0;
            end else if (cs_rise) begin
                cs_active <= 1'b0;
            end else if (cs_active && sclk_rise) begin
                // shift msb first, one bit per edge [RULE1] [RULE15]
                serial_control_word <= {serial_control_word[6:0], sdata};
                if (bit_count_o != 4'h8) begin
                    bit_count_o <= bit_count_o + 4'h1;
                end
            end
            // edges while deselected are ignored [RULE15]
        end
    end
    ////////////////////////////////////////////////////////////////
    // per-channel mode latches
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
            // d7 enables channel one, d4 channel four [RULE3]
            wire wr_en = serial_control_word[`PDM_BIT_EN_HI - ch];
            always @(posedge core_clk_i) begin
                if (rst_i) begin
                    mode[ch] <= `PDM_MODE_RESET;
                end else begin
                    if (cs_rise && wr_en) begin
                        // commit only on deselect edge [RULE2] [RULE4] [RULE8] [RULE10]
                        mode[ch] <= {serial_control_word[`PDM_BIT_LOW_LEAK], // [RULE5]
                            serial_control_word[`PDM_BIT_SLEW_UP], // [RULE6]
                            serial_control_word[`PDM_BIT_SLEW_LO],
                            serial_control_word[`PDM_BIT_TERM]}; // [RULE7]
                    end
                    if (!rst_n_lvl) begin
                        // reset forces low leak, other bits kept [RULE9]
                        mode[ch][`PDM_MODE_LEAK] <= 1'b1;
                    end
                end
            end
            ////////////////////////////////////////////////////////
            // driver state decode and outputs
            always @(posedge core_clk_i) begin
                if (rst_i) begin
                    low_leak_select_o[ch] <= 1'b1;
                    slew_code_upper_o[ch] <= 1'b0;
                    slew_code_lower_o[ch] <= 1'b0;
                    termination_select_o[ch] <= 1'b0;
                    slew_pct_o[7*ch +: 7] <= `PDM_SLEW_100;
                    drv_state_o[5*ch +: 5] <= `PDM_DRV_OFF;
                    driver_en_o[ch] <= 1'b0;
                    comp_en_o[ch] <= 1'b0;
                    clamp_en_o[ch] <= 1'b0;
                end else begin
                    low_leak_select_o[ch] <= mode[ch][`PDM_MODE_LEAK];
                    slew_code_upper_o[ch] <= mode[ch][`PDM_MODE_SLEW_UP];
                    slew_code_lower_o[ch] <= mode[ch][`PDM_MODE_SLEW_LO];
                    termination_select_o[ch] <= mode[ch][`PDM_MODE_TERM];
                    // slew percentage lookup [RULE12]
                    case (mode[ch][2:1])
                        2'b00: slew_pct_o[7*ch +: 7] <= `PDM_SLEW_100;
                        2'b01: slew_pct_o[7*ch +: 7] <= `PDM_SLEW_75;
                        2'b10: slew_pct_o[7*ch +: 7] <= `PDM_SLEW_50;
                        default: slew_pct_o[7*ch +: 7] <= `PDM_SLEW_25;
                    endcase
                    if (mode[ch][`PDM_MODE_LEAK]) begin
                        // everything off in low leak [RULE11]
                        drv_state_o[5*ch +: 5] <= `PDM_DRV_OFF;
                        driver_en_o[ch] <= 1'b0;
                        comp_en_o[ch] <= 1'b0;
                        clamp_en_o[ch] <= 1'b0;
                    end else if (!rcv_s2[ch]) begin
                        // drive high or low [RULE13]
                        drv_state_o[5*ch +: 5] <= drv_s2[ch] ? `PDM_DRV_HIGH : `PDM_DRV_LOW;
                        driver_en_o[ch] <= 1'b1;
                        comp_en_o[ch] <= 1'b1;
                        clamp_en_o[ch] <= 1'b0; // [RULE14]
                    end else if (mode[ch][`PDM_MODE_TERM]) begin
                        // termination level [RULE7] [RULE13]
                        drv_state_o[5*ch +: 5] <= `PDM_DRV_TERM;
                        driver_en_o[ch] <= 1'b1;
                        comp_en_o[ch] <= 1'b1;
                        clamp_en_o[ch] <= 1'b0; // [RULE14]
                    end else begin
                        // high impedance, clamps on [RULE14]
                        drv_state_o[5*ch +: 5] <= `PDM_DRV_HIZ;
                        driver_en_o[ch] <= 1'b0;
                        comp_en_o[ch] <= 1'b1;
                        clamp_en_o[ch] <= 1'b1;
                    end
                end
            end
        end
    endgenerate
    // cs_n_lvl kept for readability of frame state
    wire unused_ok = cs_n_lvl;
endmodule // pdm_ctrl

// >>> rtl/pdm_defs.vh
// constants for the four-channel pin driver mode control block
// What this block does
// (RULE1) control word shifted in msb first
// (RULE2) latches update only on chip-select rising edge
// (RULE3) d7..d4 enable channels one to four
// (RULE4) any channel subset gets same mode bits
// (RULE5) d3 selects low-leakage mode
// (RULE6) d2 d1 are slew code, d2 upper
// (RULE7) termination bit picks term level or high-z
// (RULE8) each channel keeps own four mode bits
// (RULE9) reset sets low-leak, keeps other bits
// (RULE10) low-leak is per channel, writes stay local
// (RULE11) low-leak disables driver, comparators and clamps
// (RULE12) slew code 00..11 gives 100,75,50,25 percent
// (RULE13) receive and drive inputs pick driver level
// (RULE14) clamps connect only in high-impedance state
// (RULE15) eight bits per frame, clock ignored when deselected
// (RULE16) host holds reset from power-up until programming
`ifndef PDM_DEFS_VH
`define PDM_DEFS_VH
`define PDM_WORD_BITS 8
`define PDM_CHANNELS 4
`define PDM_BIT_EN_HI 7
`define PDM_BIT_LOW_LEAK 3
`define PDM_BIT_SLEW_UP 2
`define PDM_BIT_SLEW_LO 1
`define PDM_BIT_TERM 0
`define PDM_MODE_BITS 4
`define PDM_MODE_LEAK 3
`define PDM_MODE_SLEW_UP 2
`define PDM_MODE_SLEW_LO 1
`define PDM_MODE_TERM 0
`define PDM_MODE_RESET 4'h1
`define PDM_SLEW_100 7'h64
`define PDM_SLEW_75 7'h4B
`define PDM_SLEW_50 7'h32
`define PDM_SLEW_25 7'h19
`define PDM_DRV_OFF 5'h01
`define PDM_DRV_HIGH 5'h02
`define PDM_DRV_LOW 5'h04
`define PDM_DRV_TERM 5'h08
`define PDM_DRV_HIZ 5'h10
`endif

// >>> rtl/pdm_sync.v
// two-flop synchroniser with edge flags for one outside level
`timescale 1ns/1ps
module pdm_sync (
    input wire core_clk_i,
    input wire rst_i,
    input wire async_i,
    output reg level_o,
    output wire rise_o,
    output wire fall_o
);
    reg meta; // first stage, read only by level_o
    reg last; // previous synchronised level
    ////////////////////////////////////////////////////////////////
    // capture and delay
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            level_o <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= async_i;
            level_o <= meta;
            last <= level_o;
        end
    end
    // edges seen on the clean level only
    assign rise_o = level_o & ~last;
    assign fall_o = ~level_o & last;
endmodule // pdm_sync

// >>> test/pdm_ctrl_properties.sv
// checker for the mode latches and driver state of pdm_ctrl
`timescale 1ns/1ps
module pdm_ctrl_chk #(
    parameter CHANNELS = 4
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire chip_sel_n_i,
    input wire dev_reset_n_i,
    input wire [3:0] drive_data_i,
    input wire [3:0] receive_ctrl_in_i,
    input wire [3:0] low_leak_select_o,
    input wire [3:0] slew_code_upper_o,
    input wire [3:0] slew_code_lower_o,
    input wire [3:0] termination_select_o,
    input wire [27:0] slew_pct_o,
    input wire [19:0] drv_state_o,
    input wire [3:0] driver_en_o,
    input wire [3:0] comp_en_o,
    input wire [3:0] clamp_en_o,
    input wire [3:0] bit_count_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // per-channel off and high-z flags taken from the one-hot state
    wire [3:0] off_w = {drv_state_o[15], drv_state_o[10], drv_state_o[5], drv_state_o[0]};
    wire [3:0] hiz_w = {drv_state_o[19], drv_state_o[14], drv_state_o[9], drv_state_o[4]};
    // driver level picked by drive, receive and termination bit
    function automatic [4:0] dec(input d, input r, input t);
        dec = r ? (t ? 5'h08 : 5'h10) : (d ? 5'h02 : 5'h04);
    endfunction
    // slew percentage for a two-bit code
    function automatic [6:0] pct(input u, input l);
        pct = u ? (l ? 7'h19 : 7'h32) : (l ? 7'h4B : 7'h64);
    endfunction
    AST_CLAMP_HIZ: assert property (clamp_en_o == hiz_w)
        else $error("clamp enable outside high-z");
    AST_OFF_DIS: assert property ((off_w & (driver_en_o | comp_en_o | clamp_en_o)) == 4'h0)
        else $error("enable active in low-leak");
    AST_LEAK_OFF: assert property ($rose(low_leak_select_o[0]) |-> ##[0:2] drv_state_o[0])
        else $error("low-leak did not switch channel off");
    AST_ONEHOT: assert property ($onehot(drv_state_o[4:0]))
        else $error("driver state not one-hot");
    AST_SLEW: assert property ($stable({slew_code_upper_o[0], slew_code_lower_o[0]}) |->
        slew_pct_o[6:0] == pct(slew_code_upper_o[0], slew_code_lower_o[0]))
        else $error("slew percent wrong");
    AST_DECODE: assert property ((!low_leak_select_o[0] && $stable({drive_data_i[0],
        receive_ctrl_in_i[0], termination_select_o[0]}))[*5] |-> drv_state_o[4:0] ==
        dec(drive_data_i[0], receive_ctrl_in_i[0], termination_select_o[0]))
        else $error("driver state decode wrong");
    AST_NO_EARLY: assert property ((!chip_sel_n_i && dev_reset_n_i)[*6] |->
        $stable({low_leak_select_o, slew_code_upper_o, slew_code_lower_o, termination_select_o}))
        else $error("latch changed while selected");
    AST_DEVRST: assert property ((!dev_reset_n_i)[*5] |-> low_leak_select_o == 4'hF)
        else $error("device reset did not set low-leak");
    AST_KEEP: assert property ((!dev_reset_n_i && chip_sel_n_i)[*8] |->
        $stable({slew_code_upper_o, slew_code_lower_o, termination_select_o}))
        else $error("device reset changed slew or term");
    AST_COUNT: assert property (bit_count_o <= 4'h8)
        else $error("bit count above eight");
    cover property (hiz_w[1]);
    cover property (drv_state_o[3]);
    cover property ((!dev_reset_n_i)[*5]);
endmodule // pdm_ctrl_chk
bind pdm_ctrl pdm_ctrl_chk #(.CHANNELS(CHANNELS)) chk_u (.*);

// >>> test/pdm_host.sv
// host model driving the serial mode port and device reset
`timescale 1ns/1ps
module pdm_host (
    input wire core_clk_i,
    output reg ser_clk_o,
    output reg ser_data_o,
    output reg chip_sel_n_o,
    output reg dev_reset_n_o
);
    integer k;
    // idle: link clock still, deselected, reset held from power-up
    initial begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b0;
        chip_sel_n_o = 1'b1;
        dev_reset_n_o = 1'b0;
    end
    // half period of the 160 ns link clock
    task half;
        repeat (4) @(negedge core_clk_i);
    endtask
    // one link clock pulse, data set up half a period ahead
    task pulse(input b);
        begin
            ser_data_o = b;
            half;
            ser_clk_o = 1'b1;
            half;
            ser_clk_o = 1'b0;
        end
    endtask
    // eight bits msb first in one select window, then commit
    task frame(input [7:0] w);
        begin
            chip_sel_n_o = 1'b0;
            for (k = 7; k >= 0; k = k - 1)
                pulse(w[k]);
            half;
            ser_data_o = ~w[0];
            chip_sel_n_o = 1'b1;
            half;
            half;
        end
    endtask
    // link clock pulses while deselected
    task stray(input integer n);
        for (k = 0; k < n; k = k + 1)
            pulse(k[0]);
    endtask
    // drive the device reset pin
    task dreset(input v);
        dev_reset_n_o = v;
    endtask
endmodule // pdm_host

// >>> test/pdm_ctrl_tb_top.sv
// testbench for the pin driver mode control block
`timescale 1ns/1ps
module pdm_ctrl_tb_top;
    reg core_clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [3:0] drv = 4'h0;
    reg [3:0] rcv = 4'h0;
    wire sck, sdat, cs_n, dr_n;
    wire [3:0] leak, su, sl, term, den, cen, clen, cnt;
    wire [27:0] pct;
    wire [19:0] st;
    integer fail_count = 0;
    integer check_count = 0;
    integer i, c;
    reg [23:0] rows [0:6];
    reg [19:0] e;
    reg [3:0] h;
    always #10 core_clk_i = ~core_clk_i;
    pdm_host host_u (.core_clk_i(core_clk_i), .ser_clk_o(sck), .ser_data_o(sdat),
        .chip_sel_n_o(cs_n), .dev_reset_n_o(dr_n));
    pdm_ctrl dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .ser_clk_i(sck), .ser_data_i(sdat),
        .chip_sel_n_i(cs_n), .dev_reset_n_i(dr_n), .drive_data_i(drv), .receive_ctrl_in_i(rcv),
        .low_leak_select_o(leak), .slew_code_upper_o(su), .slew_code_lower_o(sl),
        .termination_select_o(term), .slew_pct_o(pct), .drv_state_o(st), .driver_en_o(den),
        .comp_en_o(cen), .clamp_en_o(clen), .bit_count_o(cnt));
    // compare one result vector
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // expected slew percentages of a latch image {leak,su,sl,term}
    function [27:0] pct_of(input [15:0] m);
        integer k;
        for (k = 0; k < 4; k = k + 1)
            pct_of[7*k +: 7] = m[8+k] ? (m[4+k] ? 7'h19 : 7'h32) : (m[4+k] ? 7'h4B : 7'h64);
    endfunction
    // verdict and end of run
    task results;
        begin
            $display("checks %0d mismatches %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // main sequence: table of words, then hand-written cases
    initial begin
        rows[0] = 24'hF0_0000;
        rows[1] = 24'h8F_1111;
        rows[2] = 24'h43_1133;
        rows[3] = 24'h25_1537;
        rows[4] = 24'h1A_95B7;
        rows[5] = 24'h0F_95B7;
        rows[6] = 24'hA2_80F2;
        repeat (5) @(negedge core_clk_i);
        rst_i = 1'b0;
        repeat (5) @(negedge core_clk_i);
        chk({leak, su, sl, term}, 28'hF00F);
        chk(st, 20'h08421);
        host_u.dreset(1'b1);
        for (i = 0; i < 7; i = i + 1) begin
            host_u.frame(rows[i][23:16]);
            chk({leak, su, sl, term}, rows[i][15:0]);
            chk(pct, pct_of(rows[i][15:0]));
        end
        host_u.stray(8);
        host_u.frame(8'h0F);
        chk({leak, su, sl, term}, 28'h80F2);
        chk(cnt, 4'h8);
        host_u.dreset(1'b0);
        repeat (8) @(negedge core_clk_i);
        chk({leak, su, sl, term}, 28'hF0F2);
        chk({st, den, cen, clen}, {20'h08421, 12'h000});
        host_u.dreset(1'b1);
        host_u.frame(8'hB1);
        host_u.frame(8'h40);
        chk({leak, su, sl, term}, 28'h000D);
        for (i = 0; i < 4; i = i + 1) begin
            drv = {i[0], ~i[0], i[0], ~i[0]};
            rcv = {4{i[1]}};
            repeat (6) @(negedge core_clk_i);
            for (c = 0; c < 4; c = c + 1)
                e[5*c +: 5] = i[1] ? (c == 1 ? 5'h10 : 5'h08) : (drv[c] ? 5'h02 : 5'h04);
            h = i[1] ? 4'h2 : 4'h0;
            chk(st, e);
            chk({den, cen, clen}, {~h, 4'hF, h});
        end
        results;
    end
endmodule // pdm_ctrl_tb_top
